// >>> inc/lesf_pkg.sv
// Constants shared by the error-status flag block and its monitors.
// Assumes a single 10 MHz controller clock.
package lesf_pkg;
	// Clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 100;
	// Heartbeat window after a transmit ends, in nanoseconds (4.0 us).
	localparam int HB_WINDOW_NS = 4000;
	// Longest time counts round down.
	localparam int HB_WINDOW_CYC = (HB_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 : HB_WINDOW_NS / CLK_PERIOD_NS;
	// Bus master ready timeout, in nanoseconds (25.6 us).
	localparam int BUS_TO_NS = 25600;
	// Least time counts round up.
	localparam int BUS_TO_CYC = (BUS_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Frame byte count that marks an overlength transmit.
	localparam int BABBLE_BYTES = 1519;
	// Port select values on the address/data select pin.
	localparam logic PORT_DATA = 1'b0;
	localparam logic PORT_ADDR = 1'b1;
	// Index of the main control/status register in the address port.
	localparam logic [1:0] MCS_INDEX = 2'h0;
	// Bit positions inside the main control/status register.
	localparam int BIT_ERR = 15;
	localparam int BIT_FLAG_LSB = 11;
	localparam int BIT_IRQ = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_STOP = 2;
	localparam int BIT_START = 1;
	// Number of sticky error flags (bus timeout, missed, heartbeat, overlength).
	localparam int NUM_FLAGS = 4;
	// Flag order inside the flag vector, lowest register bit first.
	localparam int FL_BUSTO = 0;
	localparam int FL_MISS = 1;
	localparam int FL_HB = 2;
	localparam int FL_OVERLENGTH_TRANSMIT_FLAG = 3;
	// Values after reset.
	localparam logic RST_STOP = 1'b1;
	localparam logic [1:0] RST_RAP = 2'h0;
	localparam logic [15:0] RST_RDATA = 16'h0000;
endpackage

// >>> inc/lesf_mon_if.sv
// Carrier between the flag register core and its two event monitors.
// All signals are on the controller clock.
`timescale 1ns/1ps
interface lesf_mon_if;
	logic tx_active; // Transmitter is sending a frame.
	logic tx_byte; // One frame byte went out this cycle.
	logic coll_seen; // Synchronised collision input.
	logic dma_addr_valid; // Bus master address is being driven.
	logic dma_ready; // Memory answered the bus master cycle.
	logic babble_evt; // Pulse: overlength transmit detected.
	logic hb_miss_evt; // Pulse: no heartbeat after a transmit.
	logic bus_to_evt; // Pulse: bus master timed out.
	modport core (output tx_active, tx_byte, coll_seen, dma_addr_valid, dma_ready,
		input babble_evt, hb_miss_evt, bus_to_evt);
	modport tx_mon (input tx_active, tx_byte, coll_seen, output babble_evt, hb_miss_evt);
	modport bus_mon (input dma_addr_valid, dma_ready, output bus_to_evt);
endinterface

// >>> verilog/lesf_tx_monitor.sv
// Transmit monitor: overlength frame detection and heartbeat check.
// Assumes synchronous inputs and a synchronised collision level.
`timescale 1ns/1ps
module lesf_tx_monitor import lesf_pkg::*; #(
	parameter int MAX_BYTES = BABBLE_BYTES,
	parameter int WIN_CYC = HB_WINDOW_CYC
) (
	// Clock, enable and reset.
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic rstn_i,
	// Monitor carrier.
	lesf_mon_if.tx_mon mon
);
	// The counters are 11 and 8 bits wide.
	initial begin
		if (MAX_BYTES < 1 || MAX_BYTES > 2047 || WIN_CYC < 1 || WIN_CYC > 255) begin
			$error("lesf_tx_monitor: parameter out of range");
		end
	end

	// Heartbeat watch states.
	typedef enum logic [2:0] {HB_IDLE = 3'b001, HB_TX = 3'b010, HB_WIN = 3'b100} lesf_hb_t;
	lesf_hb_t st_ff, nxt_st;
	logic [10:0] bytes_ff, nxt_bytes; // Bytes sent in this frame.
	logic [7:0] win_ff, nxt_win; // Cycles left in the heartbeat window.
	logic heard_ff, nxt_heard; // Collision seen during frame or window.
	logic overlength_transmit_flag_ff, nxt_overlength_transmit_flag; // Overlength pulse.
	logic hb_ff, nxt_hb; // Heartbeat missing pulse.

	// Next state. The byte count goes on after the overlength mark,
	// so the frame is never cut short by it.
	always_comb begin
		nxt_st = st_ff;
		nxt_bytes = bytes_ff;
		nxt_win = win_ff;
		nxt_heard = heard_ff | mon.coll_seen;
		nxt_overlength_transmit_flag = 1'b0;
		nxt_hb = 1'b0;
		case (st_ff)
			HB_IDLE: begin
				nxt_heard = mon.coll_seen;
				nxt_bytes = 11'h000;
				if (mon.tx_active) begin
					nxt_st = HB_TX;
					// A byte may leave in the very cycle the frame starts; it counts too.
					nxt_bytes = {10'h000, mon.tx_byte}; // R05
					nxt_overlength_transmit_flag = mon.tx_byte && (MAX_BYTES == 1); // R05
				end
			end
			HB_TX: begin
				if (mon.tx_byte && bytes_ff != 11'h7ff) begin
					nxt_bytes = bytes_ff + 11'h001;
					nxt_overlength_transmit_flag = (bytes_ff + 11'h001) == 11'(MAX_BYTES); // R05 R06
				end
				if (!mon.tx_active) begin
					nxt_st = HB_WIN;
					nxt_win = 8'(WIN_CYC);
				end
			end
			HB_WIN: begin
				nxt_win = win_ff - 8'h01;
				if (win_ff == 8'h01) begin
					nxt_hb = ~(heard_ff | mon.coll_seen); // R09
					nxt_st = HB_IDLE;
				end
			end
			default: nxt_st = HB_IDLE;
		endcase
	end

	// State registers.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff <= HB_IDLE;
			bytes_ff <= 11'h000;
			win_ff <= 8'h00;
			heard_ff <= 1'b0;
			overlength_transmit_flag_ff <= 1'b0;
			hb_ff <= 1'b0;
		end else if (ce_i) begin
			st_ff <= nxt_st;
			bytes_ff <= nxt_bytes;
			win_ff <= nxt_win;
			heard_ff <= nxt_heard;
			overlength_transmit_flag_ff <= nxt_overlength_transmit_flag;
			hb_ff <= nxt_hb;
		end
	end

	assign mon.babble_evt = overlength_transmit_flag_ff;
	assign mon.hb_miss_evt = hb_ff;
endmodule

// >>> verilog/lesf_bus_watch.sv
// Bus master ready watchdog.
// Assumes address-valid stays high until ready arrives.
`timescale 1ns/1ps
module lesf_bus_watch import lesf_pkg::*; #(
	parameter int TO_CYC = BUS_TO_CYC
) (
	// Clock, enable and reset.
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic rstn_i,
	// Monitor carrier.
	lesf_mon_if.bus_mon mon
);
	// The counter is 12 bits wide.
	initial begin
		if (TO_CYC < 1 || TO_CYC > 4095) begin
			$error("lesf_bus_watch: TO_CYC out of range");
		end
	end

	logic [11:0] cnt_ff, nxt_cnt; // Cycles waited for ready.
	logic to_ff, nxt_to; // Timeout pulse.

	// Count while waiting; fire once per stuck cycle.
	always_comb begin
		nxt_to = 1'b0;
		nxt_cnt = 12'h000;
		if (mon.dma_addr_valid && !mon.dma_ready) begin
			nxt_cnt = (cnt_ff == 12'hfff) ? cnt_ff : cnt_ff + 12'h001;
			nxt_to = (cnt_ff + 12'h001) == 12'(TO_CYC); // R16
		end
	end

	// Registers.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= 12'h000;
			to_ff <= 1'b0;
		end else if (ce_i) begin
			cnt_ff <= nxt_cnt;
			to_ff <= nxt_to;
		end
	end

	assign mon.bus_to_evt = to_ff;
endmodule

// >>> verilog/lesf_top.sv
// Error-status flags of the main control/status register, with the
// address/data register ports, interrupt pin and event monitors.
// Host strobes come from logic on the controller clock; the collision
// input is a pin and is synchronised here.
`timescale 1ns/1ps

// What this block does
// R01 - Hardware events only ever set flags
// R02 - Bit 15 is OR of error flags
// R03 - Error summary is read only
// R04 - Summary drops on reset, stop, clears
// R05 - Overlength flag at 1519 sent bytes
// R06 - Overlength never aborts the frame
// R07 - Overlength flag raises interrupt when enabled
// R08 - Overlength flag: write one clears
// R09 - Heartbeat missing: no collision in frame or window
// R10 - Heartbeat flag: write one clears
// R11 - Heartbeat flag never interrupts
// R12 - Missed flag set on no-buffer drop
// R13 - Dropped frame reports no fifo overflow
// R14 - Missed flag raises interrupt when enabled
// R15 - Missed flag: write one clears
// R16 - Bus timeout flag after 25.6 us
// R17 - Interrupt pin low only when enabled
// R18 - Set wins over same-cycle clear
module lesf_top import lesf_pkg::*; #(
	parameter int MAX_BYTES = BABBLE_BYTES,
	parameter int WIN_CYC = HB_WINDOW_CYC,
	parameter int TO_CYC = BUS_TO_CYC
) (
	// Clock, enable and reset.
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic rstn_i,
	// Host register ports.
	input wire logic host_sel_i,
	input wire logic host_wr_i,
	input wire logic host_adr_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	output logic host_ready_o,
	// Transmitter.
	input wire logic tx_active_i,
	input wire logic tx_byte_i,
	output logic tx_abort_o,
	// Collision pin.
	input wire logic coll_i,
	// Bus master.
	input wire logic dma_addr_valid_i,
	input wire logic dma_ready_i,
	// Receive buffer manager.
	input wire logic rx_drop_nobuf_i,
	input wire logic rx_fifo_ovf_i,
	output logic rx_ovf_report_o,
	// Status and interrupt.
	output logic stop_o,
	output logic err_summary_o,
	output logic irq_n_o
);
	// Reset release synchroniser; both stages take a constant on reset.
	logic rst_meta_ff;
	logic rst_sync_ff;

	// Collision pin synchroniser; the first stage feeds only the second.
	logic coll_meta_ff;
	logic coll_sync_ff;

	// Register state.
	logic [1:0] rap_ff, nxt_rap; // Register address port.
	logic [NUM_FLAGS-1:0] flags_ff, nxt_flags; // Sticky error flags.
	logic irq_enable_ff, nxt_irq_enable; // Interrupt enable.
	logic stop_ff, nxt_stop; // Stop control.
	logic [15:0] rdata_ff, nxt_rdata; // Read data held for the host.
	logic ready_ff, nxt_ready; // Access answered.

	// Output state.
	logic irq_n_ff, nxt_irq_n; // Interrupt pin, active low.
	logic err_ff, nxt_err; // Error summary copy.
	logic abort_ff, nxt_abort; // Transmit abort request.
	logic ovf_ff, nxt_ovf; // Fifo overflow report.

	// Decoded host accesses.
	logic acc_addr; // Access to the address port.
	logic acc_mcs; // Access to the main register via data port.
	logic wr_mcs; // Write to the main register.
	logic stop_set; // Host sets the stop control.
	logic [NUM_FLAGS-1:0] w1c; // Flags the host clears.
	logic [NUM_FLAGS-1:0] evt; // Flags the hardware sets.
	logic [15:0] mcs_view; // Current main register contents.
	logic irq_flag; // Interrupt flag from current flags.
	logic nxt_irq_flag; // Interrupt flag from next flags.

	// Monitor carrier.
	lesf_mon_if mon ();

	// The reset release is not gated by the clock enable, so a frozen
	// block still leaves reset cleanly once the enable returns.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Collision synchroniser.
	always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			coll_meta_ff <= 1'b0;
			coll_sync_ff <= 1'b0;
		end else if (ce_i) begin
			coll_meta_ff <= coll_i;
			coll_sync_ff <= coll_meta_ff;
		end
	end

	// Drive the monitors.
	assign mon.tx_active = tx_active_i;
	assign mon.tx_byte = tx_byte_i;
	assign mon.coll_seen = coll_sync_ff;
	assign mon.dma_addr_valid = dma_addr_valid_i;
	assign mon.dma_ready = dma_ready_i;

	// Overlength and heartbeat monitor.
	lesf_tx_monitor #(
		.MAX_BYTES(MAX_BYTES),
		.WIN_CYC(WIN_CYC)
	) u_tx_mon (
		.core_clk_i(core_clk_i),
		.ce_i(ce_i),
		.rstn_i(rst_sync_ff),
		.mon(mon.tx_mon)
	);

	// Bus master ready watchdog.
	lesf_bus_watch #(
		.TO_CYC(TO_CYC)
	) u_bus_watch (
		.core_clk_i(core_clk_i),
		.ce_i(ce_i),
		.rstn_i(rst_sync_ff),
		.mon(mon.bus_mon)
	);

	// Host access decode. The other three registers are outside this
	// block: they read as zero and writes to them are dropped.
	always_comb begin
		acc_addr = host_sel_i && host_adr_i == PORT_ADDR;
		acc_mcs = host_sel_i && host_adr_i == PORT_DATA && rap_ff == MCS_INDEX;
		wr_mcs = acc_mcs && host_wr_i;
		stop_set = wr_mcs && host_wdata_i[BIT_STOP];
		// Writing zero to a flag leaves it alone; stop clears them all.
		w1c = {NUM_FLAGS{stop_set}};
		if (wr_mcs) begin
			w1c = w1c | host_wdata_i[BIT_FLAG_LSB +: NUM_FLAGS]; // R08 R10 R15
		end
	end

	// Hardware set conditions, one per flag.
	always_comb begin
		evt = '0;
		evt[FL_BUSTO] = mon.bus_to_evt; // R16
		evt[FL_MISS] = rx_drop_nobuf_i; // R12
		evt[FL_HB] = mon.hb_miss_evt; // R09
		evt[FL_OVERLENGTH_TRANSMIT_FLAG] = mon.babble_evt; // R05
	end

	// Interrupt flag leaves the heartbeat flag out on purpose.
	always_comb begin
		irq_flag = flags_ff[FL_OVERLENGTH_TRANSMIT_FLAG] | flags_ff[FL_MISS] | flags_ff[FL_BUSTO]; // R11
		nxt_irq_flag = nxt_flags[FL_OVERLENGTH_TRANSMIT_FLAG] | nxt_flags[FL_MISS] | nxt_flags[FL_BUSTO]; // R07 R14 R11
	end

	// Read view of the main register. The summary is computed from the
	// flags, so no write can touch it.
	always_comb begin
		mcs_view = 16'h0000;
		mcs_view[BIT_ERR] = |flags_ff; // R02 R03
		mcs_view[BIT_FLAG_LSB +: NUM_FLAGS] = flags_ff;
		mcs_view[BIT_IRQ] = irq_flag;
		mcs_view[BIT_IRQ_ENABLE] = irq_enable_ff;
		mcs_view[BIT_STOP] = stop_ff;
	end

	// Next register values. A flag is the OR of its old value and the new
	// event; the event term sits outside the clear, so an event in the
	// clearing cycle survives.
	always_comb begin
		nxt_flags = (flags_ff & ~w1c) | evt; // R01 R18
		nxt_rap = rap_ff;
		nxt_irq_enable = irq_enable_ff;
		nxt_stop = stop_ff;
		nxt_rdata = rdata_ff;
		nxt_ready = host_sel_i;
		if (acc_addr) begin
			// Address port: only the low two bits are kept.
			if (host_wr_i) begin
				nxt_rap = host_wdata_i[1:0];
			end else begin
				nxt_rdata = {14'h0000, rap_ff};
			end
		end else if (host_sel_i) begin
			// Data port.
			if (!host_wr_i) begin
				nxt_rdata = acc_mcs ? mcs_view : 16'h0000;
			end
		end
		if (wr_mcs) begin
			if (host_wdata_i[BIT_STOP]) begin
				// Stop wins over any enable in the same write.
				nxt_stop = 1'b1;
				nxt_irq_enable = 1'b0;
			end else begin
				nxt_irq_enable = host_wdata_i[BIT_IRQ_ENABLE];
				if (host_wdata_i[BIT_START]) begin
					nxt_stop = 1'b0;
				end
			end
		end
	end

	// Next output values; the summary and interrupt pin are taken from the next
	// register state so those pins agree with the register in the same cycle.
	always_comb begin
		nxt_err = |nxt_flags; // R04
		nxt_irq_n = ~(nxt_irq_enable & nxt_irq_flag); // R17 R07 R14
		// Only a bus timeout stops the transmitter; overlength lets the
		// frame run to its end.
		nxt_abort = mon.bus_to_evt; // R06
		// With no ring entry there is nowhere to write overflow status.
		nxt_ovf = rx_fifo_ovf_i & ~rx_drop_nobuf_i; // R13
	end

	// Register stage for everything above.
	always_ff @(posedge core_clk_i or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			rap_ff <= RST_RAP;
			flags_ff <= '0;
			irq_enable_ff <= 1'b0;
			stop_ff <= RST_STOP;
			rdata_ff <= RST_RDATA;
			ready_ff <= 1'b0;
			irq_n_ff <= 1'b1;
			err_ff <= 1'b0;
			abort_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else if (ce_i) begin
			rap_ff <= nxt_rap;
			flags_ff <= nxt_flags;
			irq_enable_ff <= nxt_irq_enable;
			stop_ff <= nxt_stop;
			rdata_ff <= nxt_rdata;
			ready_ff <= nxt_ready;
			irq_n_ff <= nxt_irq_n;
			err_ff <= nxt_err;
			abort_ff <= nxt_abort;
			ovf_ff <= nxt_ovf;
		end
	end

	// Outputs straight from flip-flops.
	assign host_rdata_o = rdata_ff;
	assign host_ready_o = ready_ff;
	assign tx_abort_o = abort_ff;
	assign rx_ovf_report_o = ovf_ff;
	assign stop_o = stop_ff;
	assign err_summary_o = err_ff;
	assign irq_n_o = irq_n_ff;
endmodule

// >>> tb/lesf_host_model.sv
// Host model: single accesses on the register ports of the flag block.
// Assumes the block answers every strobe exactly one clock later.
`timescale 1ns/1ps
module lesf_host_model (
	// Clock.
	input wire logic core_clk_i,
	// Strobes toward the block.
	output logic host_sel_o,
	output logic host_wr_o,
	output logic host_adr_o,
	output logic [15:0] host_wdata_o,
	// Answer from the block.
	input wire logic host_ready_i,
	input wire logic [15:0] host_rdata_i
);
	// Lines start idle before any access.
	initial begin
		host_sel_o = 1'b0;
		host_wr_o = 1'b0;
		host_adr_o = 1'b0;
		host_wdata_o = 16'h0000;
	end
	// The strobe is a one-cycle pulse, so the answer is taken while ready stands.
	// Released write and data lines carry the inverse of the last value so stale data never looks fresh; the port select line keeps its value.
	task automatic xfer(input logic wr, input logic adr, input logic [15:0] wd, output logic [15:0] rd);
		rd = 16'hxxxx;
		@(negedge core_clk_i);
		host_sel_o = 1'b1;
		host_wr_o = wr;
		host_adr_o = adr;
		host_wdata_o = wd;
		@(negedge core_clk_i);
		host_sel_o = 1'b0;
		host_wr_o = ~wr;
		host_wdata_o = ~wd;
		// A missing ready leaves the answer unknown, which no compare accepts.
		if (host_ready_i === 1'b1) begin
			rd = host_rdata_i;
		end
	endtask
endmodule

// >>> tb/lesf_top_checker.sv
// Concurrent checks on the ports of the error-status flag block.
// Assumes the clock enable is held high by the bench.
`timescale 1ns/1ps
module lesf_top_checker import lesf_pkg::*; #(
	parameter int MAX_BYTES = BABBLE_BYTES,
	parameter int WIN_CYC = HB_WINDOW_CYC,
	parameter int TO_CYC = BUS_TO_CYC
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Host port.
	input wire logic host_sel_i,
	input wire logic host_wr_i,
	input wire logic host_adr_i,
	input wire logic [15:0] host_wdata_i,
	input wire logic host_ready_o,
	// Events and status.
	input wire logic dma_addr_valid_i,
	input wire logic dma_ready_i,
	input wire logic rx_drop_nobuf_i,
	input wire logic rx_fifo_ovf_i,
	input wire logic rx_ovf_report_o,
	input wire logic tx_abort_o,
	input wire logic stop_o,
	input wire logic err_summary_o,
	input wire logic irq_n_o
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// A data-port write with the stop bit set.
	logic stop_wr;
	assign stop_wr = host_sel_i && host_wr_i && !host_adr_i && host_wdata_i[BIT_STOP];
	a_ready_follows: assert property (host_sel_i |=> host_ready_o) else $error("ready missing after strobe");
	a_summary_sticky: assert property (err_summary_o && !host_sel_i && !$past(host_sel_i) |=> err_summary_o)
		else $error("summary dropped without a host write");
	a_irq_means_error: assert property (!irq_n_o |-> ##[0:1] err_summary_o)
		else $error("interrupt without error flag");
	a_stop_clears_all: assert property (stop_wr |=> stop_o && irq_n_o ##[0:1] !err_summary_o)
		else $error("stop write did not clear");
	a_no_ovf_on_drop: assert property (rx_drop_nobuf_i |=> !rx_ovf_report_o)
		else $error("overflow reported on dropped frame");
	a_ovf_passes: assert property (rx_fifo_ovf_i && !rx_drop_nobuf_i |=> rx_ovf_report_o)
		else $error("overflow not reported");
	a_miss_sets_err: assert property (rx_drop_nobuf_i |-> ##[1:2] err_summary_o)
		else $error("missed frame not flagged");
	a_abort_needs_stall: assert property (!dma_addr_valid_i [*4] |=> !tx_abort_o)
		else $error("abort without bus stall");
	a_timeout_flags: assert property ((dma_addr_valid_i && !dma_ready_i) [*8] |-> ##[0:4] err_summary_o)
		else $error("bus timeout not flagged");
	// Main scenarios reached.
	c_drop: cover property (rx_drop_nobuf_i);
	c_irq: cover property (!irq_n_o);
	c_abort: cover property (tx_abort_o);
	c_stop: cover property (stop_wr);
endmodule
bind lesf_top lesf_top_checker #(.MAX_BYTES(MAX_BYTES), .WIN_CYC(WIN_CYC), .TO_CYC(TO_CYC)) lesf_top_checker_i (.*);

// >>> tb/lesf_top_test.sv
// Self-checking bench for the error-status flag block.
// Assumes the host model and checker are compiled with it.
`timescale 1ns/1ps
module lesf_top_test;
	// Short counts keep the run brief.
	localparam int MAXB = 20;
	localparam int WIN = 4;
	localparam int TOC = 8;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic sel, wr, adr, ready, txa = 1'b0, txb = 1'b0, abrt, coll = 1'b0;
	logic dav = 1'b0, drdy = 1'b0, drop = 1'b0, ovf = 1'b0, ovfr, stop, err, irqn, abort_seen = 1'b0;
	logic [15:0] wd, rdata, rd;
	int err_count = 0, checks = 0;
	always #50 clk = ~clk;
	lesf_top #(.MAX_BYTES(MAXB), .WIN_CYC(WIN), .TO_CYC(TOC)) lesf_top_i (.core_clk_i(clk), .ce_i(ce),
		.rstn_i(rstn), .host_sel_i(sel), .host_wr_i(wr), .host_adr_i(adr), .host_wdata_i(wd),
		.host_rdata_o(rdata), .host_ready_o(ready), .tx_active_i(txa), .tx_byte_i(txb), .tx_abort_o(abrt),
		.coll_i(coll), .dma_addr_valid_i(dav), .dma_ready_i(drdy), .rx_drop_nobuf_i(drop),
		.rx_fifo_ovf_i(ovf), .rx_ovf_report_o(ovfr), .stop_o(stop), .err_summary_o(err), .irq_n_o(irqn));
	lesf_host_model lesf_host_model_i (.core_clk_i(clk), .host_sel_o(sel), .host_wr_o(wr), .host_adr_o(adr),
		.host_wdata_o(wd), .host_ready_i(ready), .host_rdata_i(rdata));
	// The abort is a short pulse, so it is latched for later checks.
	always @(posedge clk) begin
		if (abrt === 1'b1) begin
			abort_seen <= 1'b1;
		end
	end
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Bit 1, the start bit, is masked; the block always reads it as zero.
	task automatic rd_chk(input logic [15:0] exp);
		lesf_host_model_i.xfer(1'b0, 1'b0, 16'h0000, rd);
		check("main register", exp, rd & 16'hfffd);
	endtask
	task automatic wr_main(input logic [15:0] d);
		lesf_host_model_i.xfer(1'b1, 1'b0, d, rd);
	endtask
	task automatic t_reset;
		rd_chk(16'h0004);
		check("irq pin", 16'h0001, {15'h0, irqn});
		lesf_host_model_i.xfer(1'b1, 1'b1, 16'h0001, rd);
		lesf_host_model_i.xfer(1'b0, 1'b1, 16'h0000, rd);
		check("address port", 16'h0001, rd);
		wr_main(16'h0040);
		lesf_host_model_i.xfer(1'b0, 1'b0, 16'h0000, rd);
		check("unselected data", 16'h0000, rd);
		lesf_host_model_i.xfer(1'b1, 1'b1, 16'h0000, rd);
		wr_main(16'h0002);
		wr_main(16'h0040);
		rd_chk(16'h0040);
		check("stop pin", 16'h0000, {15'h0, stop});
	endtask
	task automatic t_missed;
		drop = 1'b1;
		ovf = 1'b1;
		cyc(1);
		drop = 1'b0;
		ovf = 1'b0;
		check("overflow on drop", 16'h0000, {15'h0, ovfr});
		ovf = 1'b1;
		cyc(1);
		ovf = 1'b0;
		check("overflow alone", 16'h0001, {15'h0, ovfr});
		cyc(2);
		rd_chk(16'h90c0);
		check("irq pin", 16'h0000, {15'h0, irqn});
		wr_main(16'h0040);
		rd_chk(16'h90c0);
		wr_main(16'h8040);
		rd_chk(16'h90c0);
		wr_main(16'h1040);
		rd_chk(16'h0040);
		check("summary pin", 16'h0000, {15'h0, err});
	endtask
	task automatic t_babble;
		txa = 1'b1;
		coll = 1'b1;
		for (int i = 0; i < MAXB + 3; i++) begin
			txb = 1'b1;
			cyc(1);
			txb = 1'b0;
			coll = 1'b0;
			cyc(1);
			if (i == MAXB - 2) begin
				cyc(3);
				rd_chk(16'h0040);
			end
		end
		rd_chk(16'hc0c0);
		check("irq pin", 16'h0000, {15'h0, irqn});
		check("abort", 16'h0000, {15'h0, abort_seen});
		txa = 1'b0;
		cyc(WIN + 10);
		rd_chk(16'hc0c0);
		wr_main(16'h4040);
		rd_chk(16'h0040);
	endtask
	task automatic t_heartbeat;
		txa = 1'b1;
		cyc(3);
		txa = 1'b0;
		cyc(WIN + 10);
		rd_chk(16'ha040);
		check("irq pin", 16'h0001, {15'h0, irqn});
		wr_main(16'h0004);
		rd_chk(16'h0004);
		check("summary pin", 16'h0000, {15'h0, err});
		wr_main(16'h0002);
		wr_main(16'h0040);
	endtask
	task automatic t_timeout;
		dav = 1'b1;
		cyc(TOC - 2);
		drdy = 1'b1;
		cyc(1);
		dav = 1'b0;
		drdy = 1'b0;
		cyc(3);
		rd_chk(16'h0040);
		dav = 1'b1;
		cyc(TOC + 6);
		dav = 1'b0;
		cyc(3);
		check("abort", 16'h0001, {15'h0, abort_seen});
		rd_chk(16'h88c0);
		wr_main(16'h0840);
		rd_chk(16'h0040);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(100 * 5000);
		err_count++;
		conclude();
	end
	initial begin
		cyc(16);
		rstn = 1'b1;
		cyc(4);
		t_reset();
		t_missed();
		t_babble();
		t_heartbeat();
		t_timeout();
		conclude();
	end
endmodule
